//--- logic/nvsc_host.sv
// Host controller driving the nvSRAM pins for access, store and recall
`timescale 1ns/100ps
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYC,
  parameter int RECALL_CYCLES = RECALL_CYC,
  parameter int HREQ_CYCLES = HREQ_CYC,
  parameter int BUSY_TIMEOUT = STORE_CYC + HREQ_CYC
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire nvsc_req_t req,
  output logic req_ready_r,
  output logic [DATA_W-1:0] rdata_r,
  output logic done_r,
  output logic nv_busy_r,
  output nvsc_bus_t bus_r,
  output logic [DATA_W-1:0] dq_o_r,
  output logic dq_oe_r,
  input wire logic [DATA_W-1:0] dq_i,
  output logic sb_o_r,
  output logic sb_oe_r,
  input wire logic sb_i
);
  typedef enum logic [2:0] {
    NVSC_IDLE, NVSC_ACC, NVSC_GAP, NVSC_SEQ, NVSC_HREQ, NVSC_WAIT, NVSC_HOLD
  } nvsc_state_t;

  nvsc_state_t state_r;
  nvsc_op_t op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] step_r;
  logic [13:0] seq_addr;
  logic seq_go;

  // Saturating compare used for every timed phase
  function automatic logic cnt_done(input logic [CNT_W-1:0] c,
                                    input int lim);
    cnt_done = c >= CNT_W'(lim - 1);
  endfunction

  nvsc_seq_rom u_rom (
    .mclk(mclk),
    .rstn(rstn),
    .step(step_r),
    .recall(op_r == NVSC_OP_RECALL),
    .addr_r(seq_addr)
  );

  assign seq_go = req_valid && req_ready_r;

  // Main sequencer; sequence steps are CE-only reads so no stray access
  // can fall between them and abort the chain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= NVSC_IDLE;
      op_r <= NVSC_OP_READ;
      addr_r <= '0;
      cnt_r <= '0;
      step_r <= 3'd0;
    end else begin
      case (state_r)
        NVSC_IDLE: begin
          cnt_r <= '0;
          step_r <= 3'd0;
          if (seq_go) begin
            op_r <= req.op;
            addr_r <= req.addr;
            case (req.op)
              NVSC_OP_STORE: state_r <= NVSC_GAP;
              NVSC_OP_RECALL: state_r <= NVSC_GAP;
              default: state_r <= NVSC_ACC;
            endcase
          end
        end
        NVSC_ACC: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_done(cnt_r, ACC_CYC)) begin
            cnt_r <= '0;
            state_r <= (op_r == NVSC_OP_READ || op_r == NVSC_OP_WRITE)
              ? NVSC_HOLD : NVSC_GAP;
          end
        end
        NVSC_GAP: begin
          // CE high between steps gives each read its own falling edge
          cnt_r <= cnt_r + 1'b1;
          if (cnt_done(cnt_r, ACC_CYC)) begin
            cnt_r <= '0;
            if (op_r == NVSC_OP_READ || op_r == NVSC_OP_WRITE) begin
              state_r <= NVSC_IDLE;
            end else if (step_r == 3'(SEQ_LEN)) begin
              state_r <= NVSC_WAIT;
            end else begin
              state_r <= NVSC_SEQ;
            end
          end
        end
        NVSC_SEQ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_done(cnt_r, ACC_CYC)) begin
            cnt_r <= '0;
            step_r <= step_r + 3'd1;
            state_r <= NVSC_GAP;
          end
        end
        NVSC_HREQ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_done(cnt_r, HREQ_CYCLES)) begin
            cnt_r <= '0;
            state_r <= NVSC_WAIT;
          end
        end
        NVSC_WAIT: begin
          // Wait out the recall; for a store, wait it out and then for the busy pin to rise, giving up at BUSY_TIMEOUT
          cnt_r <= cnt_r + 1'b1;
          if (op_r == NVSC_OP_RECALL) begin
            if (cnt_done(cnt_r, RECALL_CYCLES)) begin
              state_r <= NVSC_IDLE;
            end
          end else if ((cnt_done(cnt_r, STORE_CYCLES) && sb_i) ||
                       cnt_done(cnt_r, BUSY_TIMEOUT)) begin
            state_r <= NVSC_IDLE;
          end
        end
        NVSC_HOLD: state_r <= NVSC_GAP;
        default: state_r <= NVSC_IDLE;
      endcase
      // Pin-store request is a store op with the top address bit set
      if (state_r == NVSC_IDLE && seq_go && req.op == NVSC_OP_STORE &&
          req.addr[ADDR_W-1]) begin
        state_r <= NVSC_HREQ;
      end
    end
  end

  // Chip pins; CE high outside strobes keeps each step CE-controlled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_o_r <= '0;
      dq_oe_r <= 1'b0;
    end else begin
      bus_r.ce_n <= !(state_r == NVSC_ACC || state_r == NVSC_SEQ);
      bus_r.we_n <= !(state_r == NVSC_ACC && op_r == NVSC_OP_WRITE);
      bus_r.oe_n <= !(state_r == NVSC_ACC && op_r == NVSC_OP_READ);
      if (state_r == NVSC_SEQ || state_r == NVSC_GAP) begin
        bus_r.addr <= {1'b0, seq_addr};
      end else begin
        bus_r.addr <= addr_r;
      end
      // Latch write data at accept so a changing request cannot corrupt it
      if (seq_go) begin
        dq_o_r <= req.wdata;
      end
      dq_oe_r <= state_r == NVSC_ACC && op_r == NVSC_OP_WRITE;
    end
  end

  // Busy pin: driven low only during a pin-store request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sb_o_r <= 1'b1;
      sb_oe_r <= 1'b0;
    end else begin
      sb_o_r <= 1'b0;
      sb_oe_r <= state_r == NVSC_HREQ;
    end
  end

  // Handshake and read capture; busy stops new accesses
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      req_ready_r <= 1'b0;
      rdata_r <= '0;
      done_r <= 1'b0;
      nv_busy_r <= 1'b0;
    end else begin
      req_ready_r <= state_r == NVSC_IDLE && !seq_go && sb_i;
      done_r <= state_r != NVSC_IDLE && state_r != NVSC_HOLD &&
        cnt_done(cnt_r, ACC_CYC) && state_r == NVSC_GAP &&
        (op_r == NVSC_OP_READ || op_r == NVSC_OP_WRITE);
      if (state_r == NVSC_ACC && op_r == NVSC_OP_READ &&
          cnt_done(cnt_r, ACC_CYC)) begin
        rdata_r <= dq_i;
      end
      nv_busy_r <= state_r == NVSC_HREQ || state_r == NVSC_WAIT || !sb_i;
    end
  end
endmodule

//--- pkg/nvsc_pkg.sv
// Package of constants and carrier types for the nvSRAM host controller
package nvsc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  localparam logic [13:0] SEQ_A0 = 14'h0E38;
  localparam logic [13:0] SEQ_A1 = 14'h31C7;
  localparam logic [13:0] SEQ_A2 = 14'h03E0;
  localparam logic [13:0] SEQ_A3 = 14'h3C1F;
  localparam logic [13:0] SEQ_A4 = 14'h303F;
  localparam logic [13:0] SEQ_STORE = 14'h0FC0;
  localparam logic [13:0] SEQ_RECALL = 14'h0C63;
  // Bus timing in cycles of mclk
  localparam int CLK_PS = 4000;
  localparam int ACC_NS = 48;
  localparam int ACC_CYC = (ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int STORE_MS = 10;
  // Scaled in nanoseconds first so the product stays inside 32 bits
  localparam int STORE_CYC = STORE_MS * 1000 * 1000 / (CLK_PS / 1000);
  localparam int RECALL_US = 200;
  localparam int RECALL_CYC = RECALL_US * 1000 * 1000 / CLK_PS;
  localparam int HREQ_US = 20;
  localparam int HREQ_CYC = (HREQ_US * 1000 * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    NVSC_OP_READ,
    NVSC_OP_WRITE,
    NVSC_OP_STORE,
    NVSC_OP_RECALL
  } nvsc_op_t;

  typedef struct packed {
    nvsc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsc_req_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
  } nvsc_bus_t;
endpackage

//--- logic/nvsc_seq_rom.sv
// Sequence address table, one registered word out per step
`timescale 1ns/100ps
module nvsc_seq_rom
  import nvsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] step,
  input wire logic recall,
  output logic [13:0] addr_r
);
  // Registered read keeps the address path off the step decode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 14'h0000;
    end else begin
      case (step)
        3'd0: addr_r <= SEQ_A0;
        3'd1: addr_r <= SEQ_A1;
        3'd2: addr_r <= SEQ_A2;
        3'd3: addr_r <= SEQ_A3;
        3'd4: addr_r <= SEQ_A4;
        3'd5: addr_r <= recall ? SEQ_RECALL : SEQ_STORE;
        default: addr_r <= SEQ_A0;
      endcase
    end
  end
endmodule

//--- bench/nvsc_host_sva.sv
// Pin-level assertions for the host controller
`timescale 1ns/100ps
module nvsc_host_sva
  import nvsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req_ready_r,
  input wire nvsc_bus_t bus_r,
  input wire logic dq_oe_r,
  input wire logic sb_o_r,
  input wire logic sb_oe_r,
  input wire logic sb_i
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Store request pin is open drain: only ever pulled low
  a_pin_drives_low: assert property (sb_oe_r |-> !sb_o_r)
    else $error("store pin driven high");
  a_pin_req_len: assert property ($rose(sb_oe_r) |-> sb_oe_r[*8])
    else $error("store request too short");
  a_busy_refuse: assert property (!sb_i && $past(!sb_i) |-> !req_ready_r)
    else $error("ready while store busy");
  // Access shapes on the chip pins
  a_no_write_busy: assert property (!sb_i || sb_oe_r |-> bus_r.we_n)
    else $error("write while store pin low");
  a_read_no_drive: assert property (!bus_r.ce_n && !bus_r.oe_n |-> !dq_oe_r)
    else $error("data driven during read");
  a_we_oe_excl: assert property (!bus_r.we_n |-> bus_r.oe_n)
    else $error("write with output enable");
  // The store step of the sequence is a chip-enable read
  a_seq_is_read: assert property (!bus_r.ce_n &&
    bus_r.addr[13:0] == SEQ_STORE |-> bus_r.we_n)
    else $error("sequence step written");
  a_addr_stable: assert property (!bus_r.ce_n && $past(!bus_r.ce_n)
    |-> $stable(bus_r.addr))
    else $error("address moved inside access");
  c_pin_req: cover property ($rose(sb_oe_r));
  c_recall_step: cover property (!bus_r.ce_n &&
    bus_r.addr[13:0] == SEQ_RECALL);
  c_write: cover property (!bus_r.we_n && !bus_r.ce_n);
endmodule

//--- bench/nvsc_dev.sv
// Behavioural model of the nonvolatile memory device
`timescale 1ns/100ps
module nvsc_dev
  import nvsc_pkg::*;
#(
  parameter int ST = 30,
  parameter int RC = 15,
  parameter int DLY = 4
)
(
  input wire logic mclk,
  input wire nvsc_bus_t bus,
  input wire logic [DATA_W-1:0] din,
  input wire logic sb,
  output logic [DATA_W-1:0] dout,
  output logic pull_low
);
  logic [13:0] sq [6] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_STORE};
  bit [7:0] mem [int];
  bit [7:0] nv [int];
  nvsc_bus_t pb = '1;
  logic [7:0] pd;
  int s = 0, bc = 0, lc = 0, n_st = 0;
  logic wf = 0;
  initial pull_low = 1'b0;
  // Store copies SRAM out and holds the busy pin low for its length
  task automatic nvs();
    nv = mem;
    n_st++;
    bc = ST;
    pull_low <= 1'b1;
    wf = 0;
    s = 0;
  endtask
  // Access decode on chip-enable rise; nothing is served while busy
  always @(posedge mclk) begin
    pb <= bus;
    pd <= din;
    lc = sb ? 0 : lc + 1;
    dout <= (!bus.ce_n && !bus.oe_n && bus.we_n && sb && bc == 0) ?
      (mem.exists(bus.addr) ? mem[bus.addr] : 8'h00) : ~dout;
    if (bc > 0) begin
      bc--;
      if (bc == 0) pull_low <= 1'b0;
    end else if (!sb) begin
      if (lc == DLY && wf) nvs();
    end else if (!pb.ce_n && bus.ce_n) begin
      if (!pb.we_n) begin
        mem[pb.addr] = pd;
        wf = 1;
        s = 0;
      end else if (s == 5 && pb.addr[13:0] == SEQ_RECALL) begin
        mem = nv;
        bc = RC;
        wf = 0;
        s = 0;
      end else if (pb.addr[13:0] == sq[s]) begin
        if (s == 5) nvs();
        else s++;
      end else begin
        s = (pb.addr[13:0] == sq[0]) ? 1 : 0;
      end
    end
  end
endmodule

//--- bench/nvsc_host_tb.sv
// Testbench for the host controller against the device model
`timescale 1ns/100ps
module nvsc_host_tb
  import nvsc_pkg::*;
;
  logic mclk = 0, rstn = 0, req_valid = 0, pl;
  nvsc_req_t req = '0;
  logic [7:0] rdata_r, dq_o_r, dq_i;
  logic req_ready_r, done_r, nv_busy_r, dq_oe_r, sb_o_r, sb_oe_r, sb;
  nvsc_bus_t bus_r;
  int error_cnt = 0, check_count = 0;
  always #2 mclk = ~mclk;
  // Open-drain store pin with pull-up
  assign sb = ~((sb_oe_r & ~sb_o_r) | pl);
  nvsc_host #(.STORE_CYCLES(50), .RECALL_CYCLES(20), .HREQ_CYCLES(10),
    .BUSY_TIMEOUT(80)) dut (.mclk(mclk), .rstn(rstn),
    .req_valid(req_valid), .req(req), .req_ready_r(req_ready_r),
    .rdata_r(rdata_r), .done_r(done_r), .nv_busy_r(nv_busy_r),
    .bus_r(bus_r), .dq_o_r(dq_o_r), .dq_oe_r(dq_oe_r), .dq_i(dq_i),
    .sb_o_r(sb_o_r), .sb_oe_r(sb_oe_r), .sb_i(sb));
  nvsc_dev dev (.mclk(mclk), .bus(bus_r), .din(dq_o_r), .sb(sb),
    .dout(dq_i), .pull_low(pl));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One request, held until taken, then wait for idle
  task automatic op(nvsc_op_t o, logic [14:0] a, logic [7:0] d);
    int nd = 0;
    int nb = 0;
    req = '{o, a, d};
    req_valid = 1'b1;
    do @(posedge mclk); while (req_ready_r !== 1'b1);
    #1 req_valid = 1'b0;
    @(posedge mclk);
    #1;
    for (int n = 0; n < 400 && req_ready_r !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
      nd += done_r;
      nb += nv_busy_r;
    end
    chk("ready", req_ready_r, 1'b1);
    chk("done", nd, o == NVSC_OP_READ || o == NVSC_OP_WRITE);
    chk("busy", nb != 0, o == NVSC_OP_STORE || o == NVSC_OP_RECALL);
  endtask
  task automatic t_access();
    op(NVSC_OP_WRITE, 15'h1234, 8'ha5);
    op(NVSC_OP_WRITE, 15'h4e38, 8'h5a);
    op(NVSC_OP_READ, 15'h1234, 8'h00);
    chk("rdata", rdata_r, 8'ha5);
  endtask
  // Software store, repeat store with no write, then recall
  task automatic t_soft();
    int n = dev.n_st;
    op(NVSC_OP_STORE, 15'h0000, 8'h00);
    chk("sw store", dev.n_st, n + 1);
    op(NVSC_OP_STORE, 15'h0000, 8'h00);
    chk("sw store again", dev.n_st, n + 2);
    op(NVSC_OP_WRITE, 15'h1234, 8'h3c);
    op(NVSC_OP_RECALL, 15'h0000, 8'h00);
    op(NVSC_OP_READ, 15'h1234, 8'h00);
    chk("recall data", rdata_r, 8'ha5);
  endtask
  // Pin store counts only after a write
  task automatic t_pin();
    int n = dev.n_st;
    op(NVSC_OP_WRITE, 15'h0040, 8'h77);
    op(NVSC_OP_STORE, 15'h4000, 8'h00);
    chk("pin store", dev.n_st, n + 1);
    op(NVSC_OP_STORE, 15'h4000, 8'h00);
    chk("pin store skip", dev.n_st, n + 1);
    op(NVSC_OP_READ, 15'h0040, 8'h00);
    chk("after store", rdata_r, 8'h77);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
    t_access();
    t_soft();
    t_pin();
    end_of_test();
  end
  // Watchdog at 10000 cycles, well beyond the thousand or so cycles expected
  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end
endmodule
bind nvsc_host nvsc_host_sva chk (.mclk, .rstn, .req_ready_r, .bus_r,
  .dq_oe_r, .sb_o_r, .sb_oe_r, .sb_i);
